//--- design/failsafe_sensor_defs.vh
`ifndef FAILSAFE_SENSOR_DEFS_VH
`define FAILSAFE_SENSOR_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_CONTROL       8'h00
`define REG_CONFIG        8'h04
`define REG_STATUS        8'h08
`define REG_IRQ_STATUS    8'h0c
`define REG_IRQ_MASK      8'h10
`define REG_PERIOD        8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_ENABLE_BIT   0
`define CTRL_INIT_BIT     1
`define CFG_CHAN_LSB      0
`define CFG_CHAN_MSB      7
`define CFG_USE_A_BIT     8
`define CFG_USE_B_BIT     9
`define ST_SAFE_ON_BIT    0
`define ST_ERROR_BIT      1
`define ST_CONFIGURED_BIT 2
`define ST_ACTIVE_BIT     3
`define IRQ_ERROR_BIT     0
`define IRQ_RECOVER_BIT   1

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define CONFIG_RESET      10'h100
`define IRQ_MASK_RESET    2'h0
`define PERIOD_RESET      16'h0032
`define TEST_PATTERN      8'h4d
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

//--- design/pattern_checker.v
`timescale 1ns/1ps
module pattern_checker #(
	parameter PAT_W = 8
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_arst_n,
	// Control
	input  wire             i_run,
	input  wire             i_step,
	input  wire [PAT_W-1:0] i_pattern,
	input  wire             i_sample,
	// Result
	output reg              o_tx,
	output reg              o_done,
	output reg              o_match
);
	reg [PAT_W-1:0] idx_reg;
	reg             bad_reg;
	reg [PAT_W-1:0] exp_reg;

	// ------------------------------------------------------------------
	// Drive pattern, compare echo one step later
	// ------------------------------------------------------------------
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			idx_reg <= {PAT_W{1'b0}};
			bad_reg <= 1'b0;
			exp_reg <= {PAT_W{1'b0}};
			o_tx    <= 1'b0;
			o_done  <= 1'b0;
			o_match <= 1'b0;
		end else if (!i_run) begin
			idx_reg <= {PAT_W{1'b0}};
			bad_reg <= 1'b0;
			o_tx    <= 1'b0;
			o_done  <= 1'b0;
		end else if (i_step) begin
			o_tx    <= i_pattern[idx_reg[2:0]];
			exp_reg <= {exp_reg[PAT_W-2:0], i_pattern[idx_reg[2:0]]};
			if (idx_reg != {PAT_W{1'b0}} && i_sample != exp_reg[0])
				bad_reg <= 1'b1;
			if (idx_reg == PAT_W[PAT_W-1:0]) begin
				o_done  <= 1'b1;
				o_match <= !bad_reg && (i_sample == exp_reg[0]);
				idx_reg <= {PAT_W{1'b0}};
				bad_reg <= 1'b0;
			end else begin
				o_done  <= 1'b0;
				idx_reg <= idx_reg + 1'b1;
			end
		end else begin
			o_done <= 1'b0;
		end
	end
endmodule

//--- design/clocked_failsafe_sensor_check.v
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "failsafe_sensor_defs.vh"
module clocked_failsafe_sensor_check #(
	parameter HAS_CLOCK_B = 1,
	parameter PAT_W       = 8
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_arst_n,
	// AXI4-Lite write address
	input  wire [7:0]  i_awaddr,
	input  wire        i_awvalid,
	output reg         o_awready,
	// AXI4-Lite write data
	input  wire [31:0] i_wdata,
	input  wire [3:0]  i_wstrb,
	input  wire        i_wvalid,
	output reg         o_wready,
	// AXI4-Lite write response
	output reg  [1:0]  o_bresp,
	output reg         o_bvalid,
	input  wire        i_bready,
	// AXI4-Lite read address
	input  wire [7:0]  i_araddr,
	input  wire        i_arvalid,
	output reg         o_arready,
	// AXI4-Lite read data
	output reg  [31:0] o_rdata,
	output reg  [1:0]  o_rresp,
	output reg         o_rvalid,
	input  wire        i_rready,
	// Sensor pins
	input  wire [3:0]  i_sensor_in,
	output reg         o_test_clock_out_a,
	output reg         o_test_clock_out_b,
	// Results
	output reg         o_safe_on,
	output reg         o_error,
	output reg         o_irq
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN  = 3'b010;
	localparam ST_OFF  = 3'b100;

	reg [2:0]  state_reg;
	reg        enable_reg;
	reg        init_seen_reg;
	reg [9:0]  config_reg;
	reg [1:0]  chan_reg;
	reg        use_a_reg;
	reg        use_b_reg;
	reg        configured_reg;
	reg [15:0] period_reg;
	reg [15:0] tick_reg;
	reg        step_reg;
	reg [1:0]  irq_stat_reg;
	reg [1:0]  irq_mask_reg;
	reg        aw_hold_reg;
	reg [7:0]  aw_addr_reg;
	reg        w_hold_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;

	wire       tx;
	wire       done;
	wire       match;
	wire       run;
	wire       sample;
	wire       do_write;
	wire       init_pulse;
	wire       err_event;
	wire       rec_event;
	wire       irq_clear_err;
	wire       irq_clear_rec;

	wire [31:0] cfg_merged;
	wire [31:0] per_merged;
	wire [15:0] period_eff;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					merge[k*8 +: 8] = data[k*8 +: 8];
		end
	endfunction

	function wr_hit;
		input [7:0]   addr;
		input integer pos;
		begin
			wr_hit = aw_addr_reg == addr && w_strb_reg[0] &&
				w_data_reg[pos];
		end
	endfunction

	// ------------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------------
	assign do_write = aw_hold_reg && w_hold_reg && !o_bvalid;
	assign init_pulse = do_write && wr_hit(`REG_CONTROL, `CTRL_INIT_BIT);
	assign irq_clear_err = do_write &&
		wr_hit(`REG_IRQ_STATUS, `IRQ_ERROR_BIT);
	assign irq_clear_rec = do_write &&
		wr_hit(`REG_IRQ_STATUS, `IRQ_RECOVER_BIT);
	assign cfg_merged = merge({22'h0, config_reg}, w_data_reg,
		w_strb_reg);
	assign per_merged = merge({16'h0, period_reg}, w_data_reg,
		w_strb_reg);

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_hold_reg  <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_hold_reg   <= 1'b0;
			w_data_reg   <= 32'h00000000;
			w_strb_reg   <= 4'h0;
			o_awready    <= 1'b0;
			o_wready     <= 1'b0;
			o_bvalid     <= 1'b0;
			o_bresp      <= `RESP_OKAY;
			enable_reg   <= 1'b0;
			config_reg   <= `CONFIG_RESET;
			irq_mask_reg <= `IRQ_MASK_RESET;
			period_reg   <= `PERIOD_RESET;
		end else begin
			o_awready <= !aw_hold_reg && !o_awready && i_awvalid;
			o_wready  <= !w_hold_reg && !o_wready && i_wvalid;
			if (o_awready && i_awvalid) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= i_awaddr;
			end
			if (o_wready && i_wvalid) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= i_wdata;
				w_strb_reg <= i_wstrb;
			end
			if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
			if (do_write) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				o_bvalid    <= 1'b1;
				o_bresp     <= `RESP_OKAY;
				case (aw_addr_reg)
				`REG_CONTROL: begin
					if (w_strb_reg[0])
						enable_reg <= w_data_reg[`CTRL_ENABLE_BIT];
				end
				`REG_CONFIG: begin
					config_reg <= cfg_merged[9:0];
				end
				`REG_IRQ_MASK: begin
					if (w_strb_reg[0])
						irq_mask_reg <= w_data_reg[1:0];
				end
				`REG_PERIOD: begin
					period_reg <= per_merged[15:0];
				end
				`REG_IRQ_STATUS: begin
				end
				default: begin
					o_bresp <= `RESP_SLVERR;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h00000000;
			o_rresp   <= `RESP_OKAY;
		end else begin
			o_arready <= !o_arready && !o_rvalid && i_arvalid;
			if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
			if (o_arready && i_arvalid) begin
				o_rvalid <= 1'b1;
				o_rresp  <= `RESP_OKAY;
				case (i_araddr)
				`REG_CONTROL:    o_rdata <= {31'h0, enable_reg};
				`REG_CONFIG:     o_rdata <= {22'h0, config_reg};
				`REG_STATUS:     o_rdata <= {28'h0, run,
					configured_reg, o_error, o_safe_on};
				`REG_IRQ_STATUS: o_rdata <= {30'h0, irq_stat_reg};
				`REG_IRQ_MASK:   o_rdata <= {30'h0, irq_mask_reg};
				`REG_PERIOD:     o_rdata <= {16'h0, period_reg};
				default: begin
					o_rdata <= 32'h00000000;
					o_rresp <= `RESP_SLVERR;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration capture at init
	// ------------------------------------------------------------------
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			init_seen_reg  <= 1'b0;
			configured_reg <= 1'b0;
			chan_reg       <= 2'h0;
			use_a_reg      <= 1'b0;
			use_b_reg      <= 1'b0;
		end else if (init_pulse && !init_seen_reg) begin
			init_seen_reg  <= 1'b1;
			chan_reg       <= config_reg[1:0];
			use_a_reg      <= config_reg[`CFG_USE_A_BIT];
			use_b_reg      <= config_reg[`CFG_USE_B_BIT] &&
				(HAS_CLOCK_B != 0);
			configured_reg <= config_reg[`CFG_CHAN_MSB:2] == 6'h00 &&
				(config_reg[`CFG_USE_A_BIT] ^
				(config_reg[`CFG_USE_B_BIT] && HAS_CLOCK_B != 0));
		end
	end

	// ------------------------------------------------------------------
	// Evaluation pacing
	// ------------------------------------------------------------------
	assign run = enable_reg && configured_reg;
	assign sample = i_sensor_in[chan_reg];
	// Floor of one: echo returns two cycles after a step
	assign period_eff = (period_reg == 16'h0000) ? 16'h0001 : period_reg;

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tick_reg <= 16'h0000;
			step_reg <= 1'b0;
		end else if (!run || tick_reg == 16'h0000) begin
			tick_reg <= period_eff;
			step_reg <= run;
		end else begin
			tick_reg <= tick_reg - 16'h0001;
			step_reg <= 1'b0;
		end
	end

	pattern_checker #(
		.PAT_W     (PAT_W)
	) u_check (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_run     (run),
		.i_step    (step_reg),
		.i_pattern (`TEST_PATTERN),
		.i_sample  (sample),
		.o_tx      (tx),
		.o_done    (done),
		.o_match   (match)
	);

	// ------------------------------------------------------------------
	// Result state machine
	// ------------------------------------------------------------------
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg          <= ST_IDLE;
			o_safe_on          <= 1'b0;
			o_error            <= 1'b0;
			o_test_clock_out_a <= 1'b0;
			o_test_clock_out_b <= 1'b0;
		end else begin
			o_test_clock_out_a <= run && use_a_reg && tx;
			o_test_clock_out_b <= run && use_b_reg && tx;
			case (state_reg)
			ST_IDLE: begin
				o_safe_on <= 1'b0;
				o_error   <= 1'b0;
				if (run)
					state_reg <= ST_OFF;
			end
			ST_RUN, ST_OFF: begin
				if (!run) begin
					state_reg <= ST_IDLE;
					o_safe_on <= 1'b0;
					o_error   <= 1'b0;
				end else if (done && match) begin
					state_reg <= ST_RUN;
					o_safe_on <= 1'b1;
					o_error   <= 1'b0;
				end else if (done) begin
					state_reg <= ST_OFF;
					o_safe_on <= 1'b0;
					o_error   <= 1'b1;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
				o_safe_on <= 1'b0;
				o_error   <= 1'b0;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	assign err_event = done && run && !match;
	assign rec_event = done && run && match && state_reg == ST_OFF &&
		o_error;

	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_stat_reg <= 2'h0;
			o_irq        <= 1'b0;
		end else begin
			irq_stat_reg[0] <= err_event ||
				(irq_stat_reg[0] && !irq_clear_err);
			irq_stat_reg[1] <= rec_event ||
				(irq_stat_reg[1] && !irq_clear_rec);
			o_irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end
endmodule

//--- testbench/sensor_loop_model.sv
`timescale 1ns/1ps
module sensor_loop_model (
	input  wire logic       i_clk_a,
	input  wire logic       i_clk_b,
	input  wire logic       i_damped,
	input  wire logic [1:0] i_chan,
	output logic      [3:0] o_sense
);
	logic echo;
	// Undamped coil returns no clock
	assign echo = i_damped & (i_clk_a | i_clk_b);
	// Other lines carry the inverse
	always_comb begin
		o_sense = {4{~echo}};
		o_sense[i_chan] = echo;
	end
endmodule

//--- testbench/sensor_check_assertions.sv
`timescale 1ns/1ps
module sensor_check_assertions (
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic        i_arvalid,
	input wire logic        i_bready,
	input wire logic        i_rready,
	input wire logic        o_awready,
	input wire logic        o_wready,
	input wire logic        o_arready,
	input wire logic        o_bvalid,
	input wire logic [1:0]  o_bresp,
	input wire logic        o_rvalid,
	input wire logic [31:0] o_rdata,
	input wire logic        o_test_clock_out_a,
	input wire logic        o_test_clock_out_b,
	input wire logic        o_safe_on,
	input wire logic        o_error
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);
	sequence ar_taken;
		o_arready && i_arvalid;
	endsequence
	sequence r_waiting;
		o_rvalid && !i_rready;
	endsequence
	only_one_a: assert property (!(o_safe_on && o_error))
		else $error("safe and error both high");
	one_clock_a: assert property (
		!(o_test_clock_out_a && o_test_clock_out_b))
		else $error("both test clocks high");
	err_drop_a: assert property (
		$rose(o_error) |=> o_error && !o_safe_on)
		else $error("error without safe drop");
	safe_hold_a: assert property (
		$rose(o_safe_on) |=> o_safe_on[*2])
		else $error("safe result not held");
	aw_pulse_a: assert property (o_awready |=> !o_awready)
		else $error("awready longer than one cycle");
	w_pulse_a: assert property (o_wready |=> !o_wready)
		else $error("wready longer than one cycle");
	b_hold_a: assert property (
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	read_ans_a: assert property (ar_taken |=> o_rvalid)
		else $error("read answer late");
	r_hold_a: assert property (
		r_waiting |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
endmodule

//--- testbench/clocked_failsafe_sensor_check_tb.sv
`timescale 1ns/1ps
`include "failsafe_sensor_defs.vh"
`define CHK(a, e) begin \
	comparisons++; \
	if ((a) !== (e)) begin \
		n_mismatch++; \
		$display("unexpected at %0t: %h vs %h", $time, a, e); \
	end \
end
module clocked_failsafe_sensor_check_tb;
	logic        i_clk;
	logic        i_arst_n;
	logic [7:0]  i_awaddr;
	logic        i_awvalid;
	logic [31:0] i_wdata;
	logic        i_wvalid;
	logic        i_bready;
	logic [7:0]  i_araddr;
	logic        i_arvalid;
	logic        i_rready;
	logic        damped;
	logic [1:0]  chan;
	logic [3:0]  strb;
	wire  [3:0]  i_sensor_in;
	wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	wire  [1:0]  o_bresp, o_rresp;
	wire  [31:0] o_rdata;
	wire         o_test_clock_out_a, o_test_clock_out_b;
	wire         o_safe_on, o_error, o_irq;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          cyc = 0;

	clocked_failsafe_sensor_check u_dut (
		.i_clk, .i_arst_n, .i_awaddr, .i_awvalid, .o_awready,
		.i_wdata, .i_wstrb(strb), .i_wvalid, .o_wready, .o_bresp,
		.o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
		.o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_sensor_in,
		.o_test_clock_out_a, .o_test_clock_out_b, .o_safe_on,
		.o_error, .o_irq
	);
	sensor_loop_model u_sensor (
		.i_clk_a (o_test_clock_out_a),
		.i_clk_b (o_test_clock_out_b),
		.i_damped(damped),
		.i_chan  (chan),
		.o_sense (i_sensor_in)
	);

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		logic [1:0] tk;
		tk = 2'b00;
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		while (tk != 2'b11) begin
			@(posedge i_clk);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
			tk = tk | {o_awready, o_wready};
		end
		do @(posedge i_clk); while (!o_bvalid);
		i_bready <= 1'b1;
		@(posedge i_clk);
		`CHK(o_bresp, er)
		i_bready <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input logic [1:0] er);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		do @(posedge i_clk); while (!o_arready);
		i_arvalid <= 1'b0;
		do @(posedge i_clk); while (!o_rvalid);
		i_rready <= 1'b1;
		@(posedge i_clk);
		`CHK(o_rdata, e)
		`CHK(o_rresp, er)
		i_rready <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic wait_res(input logic s, input logic e);
		int n;
		n = 0;
		while ((o_safe_on !== s || o_error !== e) && n < 400) begin
			@(posedge i_clk);
			n++;
		end
		`CHK({o_safe_on, o_error}, {s, e})
	endtask

	task automatic s_regs;
		rd(`REG_CONFIG, {22'h0, `CONFIG_RESET}, `RESP_OKAY);
		rd(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
		rd(`REG_PERIOD, {16'h0, `PERIOD_RESET}, `RESP_OKAY);
		rd(`REG_STATUS, 32'h0, `RESP_OKAY);
		rd(8'h40, 32'h0, `RESP_SLVERR);
		wr(8'h40, 32'h1, `RESP_SLVERR);
	endtask

	task automatic s_good;
		wr(`REG_PERIOD, 32'h4, `RESP_OKAY);
		wr(`REG_IRQ_MASK, 32'h2, `RESP_OKAY);
		wr(`REG_CONFIG, 32'h102, `RESP_OKAY);
		wr(`REG_CONTROL, 32'h3, `RESP_OKAY);
		wait_res(1'b1, 1'b0);
		`CHK(o_test_clock_out_b, 1'b0)
		rd(`REG_STATUS, 32'hd, `RESP_OKAY);
		wr(`REG_IRQ_STATUS, 32'h3, `RESP_OKAY);
	endtask

	task automatic s_fault;
		damped <= 1'b0;
		wait_res(1'b0, 1'b1);
		repeat (2) @(posedge i_clk);
		`CHK(o_irq, 1'b0)
		damped <= 1'b1;
		wait_res(1'b1, 1'b0);
		repeat (2) @(posedge i_clk);
		`CHK(o_irq, 1'b1)
		rd(`REG_IRQ_STATUS, 32'h3, `RESP_OKAY);
		wr(`REG_IRQ_STATUS, 32'h3, `RESP_OKAY);
		@(posedge i_clk);
		`CHK(o_irq, 1'b0)
	endtask

	task automatic s_locked;
		wr(`REG_CONFIG, 32'h203, `RESP_OKAY);
		wr(`REG_CONTROL, 32'h3, `RESP_OKAY);
		repeat (100) @(posedge i_clk);
		`CHK({o_safe_on, o_error}, 2'b10)
		chan <= 2'd3;
		wait_res(1'b0, 1'b1);
		chan <= 2'd2;
		wait_res(1'b1, 1'b0);
	endtask

	task automatic s_disable;
		wr(`REG_CONTROL, 32'h0, `RESP_OKAY);
		repeat (3) @(posedge i_clk);
		`CHK({o_safe_on, o_error}, 2'b00)
		rd(`REG_STATUS, 32'h4, `RESP_OKAY);
		wr(`REG_CONTROL, 32'h1, `RESP_OKAY);
		wait_res(1'b1, 1'b0);
	endtask

	task automatic restart;
		i_arst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
	endtask

	task automatic s_reinit;
		restart();
		`CHK({o_safe_on, o_error, o_irq, o_test_clock_out_a}, 4'h0)
		strb <= 4'h1;
		wr(`REG_PERIOD, 32'h1204, `RESP_OKAY);
		strb <= 4'hf;
		rd(`REG_PERIOD, 32'h4, `RESP_OKAY);
		wr(`REG_CONFIG, 32'h300, `RESP_OKAY);
		wr(`REG_CONTROL, 32'h3, `RESP_OKAY);
		repeat (60) @(posedge i_clk);
		`CHK({o_safe_on, o_error, o_test_clock_out_a, o_test_clock_out_b}, 4'h0)
		rd(`REG_STATUS, 32'h0, `RESP_OKAY);
		rd(`REG_CONTROL, 32'h1, `RESP_OKAY);
	endtask

	task automatic s_clock_b;
		logic seen;
		seen = 1'b0;
		restart();
		wr(`REG_PERIOD, 32'h4, `RESP_OKAY);
		chan <= 2'd1;
		wr(`REG_CONFIG, 32'h201, `RESP_OKAY);
		wr(`REG_CONTROL, 32'h3, `RESP_OKAY);
		wait_res(1'b1, 1'b0);
		repeat (60) begin
			@(posedge i_clk);
			seen = seen | o_test_clock_out_b;
			`CHK(o_test_clock_out_a, 1'b0)
		end
		`CHK(seen, 1'b1)
	endtask

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end

	initial begin
		{i_awaddr, i_awvalid, i_wdata, i_wvalid, i_bready} = '0;
		{i_araddr, i_arvalid, i_rready} = '0;
		damped = 1'b1;
		chan = 2'd2;
		strb = 4'hf;
		i_arst_n = 1'b0;
		repeat (12) @(posedge i_clk);
		i_arst_n <= 1'b1;
		s_regs();
		s_good();
		s_fault();
		s_locked();
		s_disable();
		s_reinit();
		s_clock_b();
		summarize();
	end
endmodule

bind clocked_failsafe_sensor_check sensor_check_assertions u_chk (
	.i_clk, .i_arst_n, .i_arvalid, .i_bready, .i_rready, .o_awready,
	.o_wready, .o_arready, .o_bvalid, .o_bresp, .o_rvalid, .o_rdata,
	.o_test_clock_out_a, .o_test_clock_out_b, .o_safe_on, .o_error
);
